// *** rtl/tx100_symbol_encoder.sv ***
// Transmit coding path: 4B5B encoder with delimiters on the nibble clock,
// serializer, scrambler and MLT-3 driver on the bit clock.
// Assumes TXD and TX_EN come from logic on CORE_CLK_I and that LINK_CLK_I
// runs five times faster; straps and the bypass pin are asynchronous.
`timescale 1ns/1ns
module tx100_symbol_encoder (
	// Nibble clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Bit clock
	input wire logic LINK_CLK_I,
	// MAC transmit side
	input wire logic [tx100_pkg::NIBBLE_W-1:0] TXD_I,
	input wire logic TX_EN_I,
	// Straps and mode pins
	input wire logic [tx100_pkg::ADDR_W-1:0] PHY_ADDRESS_STRAPS_I,
	input wire logic SCRAMBLE_BYPASS_I,
	// Status
	output logic TX_ACTIVE_O,
	output logic [tx100_pkg::CODE_W-1:0] CODE_GROUP_O,
	// Line drive streams
	output logic MLT3_POS_O,
	output logic MLT3_NEG_O
);
	// Nibble domain
	tx100_pkg::enc_state_e state_reg;
	tx100_pkg::enc_state_e state_next;
	logic [tx100_pkg::CODE_W-1:0] code_next;
	logic word_toggle_reg;
	// Bit domain
	logic link_rst_s1;
	logic link_rst;
	logic toggle_s1;
	logic toggle_s2;
	logic toggle_s3;
	logic [tx100_pkg::CODE_W-1:0] pending_reg;
	logic [tx100_pkg::CODE_W-1:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic [tx100_pkg::ADDR_W-1:0] straps_s1;
	logic [tx100_pkg::ADDR_W-1:0] straps_s2;
	logic bypass_s1;
	logic bypass_s2;
	logic scr_bit;

	// Standard 4B5B data mapping
	function automatic logic [tx100_pkg::CODE_W-1:0] enc4b5b(
		input logic [tx100_pkg::NIBBLE_W-1:0] nib
	);
		logic [tx100_pkg::CODE_W-1:0] cg;
		cg = 5'h1E;
		case (nib)
			4'h0: cg = 5'h1E;
			4'h1: cg = 5'h09;
			4'h2: cg = 5'h14;
			4'h3: cg = 5'h15;
			4'h4: cg = 5'h0A;
			4'h5: cg = 5'h0B;
			4'h6: cg = 5'h0E;
			4'h7: cg = 5'h0F;
			4'h8: cg = 5'h12;
			4'h9: cg = 5'h13;
			4'hA: cg = 5'h16;
			4'hB: cg = 5'h17;
			4'hC: cg = 5'h1A;
			4'hD: cg = 5'h1B;
			4'hE: cg = 5'h1C;
			4'hF: cg = 5'h1D;
			default: cg = 5'h1E;
		endcase
		return cg;
	endfunction

	// Transmit sequencing: idle, J, K, data, T, R, idle
	always_comb begin
		state_next = state_reg;
		code_next = tx100_pkg::CODE_IDLE;
		case (state_reg)
			tx100_pkg::ENC_IDLE: begin
				if (TX_EN_I) begin
					code_next = tx100_pkg::CODE_J;
					state_next = tx100_pkg::ENC_SSD_K;
				end else begin
					code_next = tx100_pkg::CODE_IDLE;
				end
			end
			tx100_pkg::ENC_SSD_K: begin
				code_next = tx100_pkg::CODE_K;
				state_next = tx100_pkg::ENC_DATA;
			end
			tx100_pkg::ENC_DATA: begin
				if (TX_EN_I) begin
					code_next = enc4b5b(TXD_I);
				end else begin
					code_next = tx100_pkg::CODE_T;
					state_next = tx100_pkg::ENC_ESD_R;
				end
			end
			tx100_pkg::ENC_ESD_R: begin
				code_next = tx100_pkg::CODE_R;
				state_next = tx100_pkg::ENC_IDLE;
			end
			default: begin
				code_next = tx100_pkg::CODE_IDLE;
				state_next = tx100_pkg::ENC_IDLE;
			end
		endcase
	end

	// Encoder state
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_reg <= tx100_pkg::ENC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// One code-group per nibble clock, flagged by a toggle for the bit domain
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			CODE_GROUP_O <= tx100_pkg::CODE_IDLE;
			word_toggle_reg <= 1'b0;
		end else begin
			CODE_GROUP_O <= code_next;
			word_toggle_reg <= ~word_toggle_reg;
		end
	end

	// Frame activity seen by the MAC side
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			TX_ACTIVE_O <= 1'b0;
		end else begin
			TX_ACTIVE_O <= (state_next != tx100_pkg::ENC_IDLE);
		end
	end

	// Reset brought into the bit domain as a level
	always_ff @(posedge LINK_CLK_I) begin
		link_rst_s1 <= RST_I;
		link_rst <= link_rst_s1;
	end

	// Strap and bypass pins pass two flops before use
	always_ff @(posedge LINK_CLK_I) begin
		straps_s1 <= PHY_ADDRESS_STRAPS_I;
		straps_s2 <= straps_s1;
		bypass_s1 <= SCRAMBLE_BYPASS_I;
		bypass_s2 <= bypass_s1;
	end

	// Toggle synchroniser; the second and third stages feed the edge compare
	always_ff @(posedge LINK_CLK_I) begin
		if (link_rst) begin
			toggle_s1 <= 1'b0;
			toggle_s2 <= 1'b0;
			toggle_s3 <= 1'b0;
		end else begin
			toggle_s1 <= word_toggle_reg;
			toggle_s2 <= toggle_s1;
			toggle_s3 <= toggle_s2;
		end
	end

	// Code-group stays stable for a whole nibble clock, so it is safe to take
	// once the toggle edge has been synchronised
	always_ff @(posedge LINK_CLK_I) begin
		if (link_rst) begin
			pending_reg <= tx100_pkg::CODE_IDLE;
		end else if (toggle_s2 != toggle_s3) begin
			pending_reg <= CODE_GROUP_O;
		end
	end

	// Five bits per code-group, first bit of the group sent first
	always_ff @(posedge LINK_CLK_I) begin
		if (link_rst) begin
			bit_cnt_reg <= tx100_pkg::BIT_FIRST;
			shift_reg <= tx100_pkg::CODE_IDLE;
		end else if (bit_cnt_reg == tx100_pkg::BIT_LAST) begin
			bit_cnt_reg <= tx100_pkg::BIT_FIRST;
			shift_reg <= pending_reg;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg <= {shift_reg[tx100_pkg::CODE_W-2:0], 1'b0};
		end
	end

	// Scrambler on the serial NRZ stream
	tx100_scrambler u_scrambler (
		.link_clk(LINK_CLK_I),
		.link_rst(link_rst),
		.seed_addr_i(straps_s2),
		.bypass_i(bypass_s2),
		.nrz_bit_i(shift_reg[tx100_pkg::CODE_W-1]),
		.scr_bit_o(scr_bit)
	);

	// NRZI and MLT-3 drive
	tx100_mlt3_driver u_mlt3 (
		.link_clk(LINK_CLK_I),
		.link_rst(link_rst),
		.bit_i(scr_bit),
		.drive_pos_o(MLT3_POS_O),
		.drive_neg_o(MLT3_NEG_O)
	);
endmodule // tx100_symbol_encoder

// *** pkg/tx100_pkg.sv ***
// Constants shared by the 100 Mb/s transmit coding path.
// Assumes a nibble clock of 25 MHz and a bit clock five times faster.
// How it works
// - Every MAC nibble becomes a 5-bit code-group
// - First two preamble nibbles become J then K
// - Later preamble and data nibbles encoded one-to-one
// - TX_EN drop appends T then R
// - Idle code-groups fill until TX_EN returns
// - Scrambler is an 11-bit closed-loop LFSR
// - LFSR output XORed with serial NRZ bits
// - Scrambler seed loaded from PHY address straps
// - Bypass pin skips the scrambler
// - Scrambled stream converted to NRZI
// - NRZI split into two alternating drive streams
// - Line driven only with MLT-3, no binary
// - Serial stream runs five bits per nibble
// - Sequencing follows the standard transmit state machine
// - MAC nibbles and TX_EN synchronous to core clock
package tx100_pkg;
	localparam int CODE_W = 5;
	localparam int NIBBLE_W = 4;
	localparam int ADDR_W = 5;
	localparam int LFSR_W = 11;
	// Feedback taps of x^11 + x^9 + 1
	localparam int LFSR_TAP_HI = 10;
	localparam int LFSR_TAP_LO = 8;
	// Upper seed bits above the straps keep the LFSR out of the all-zero lockup
	localparam logic [5:0] SEED_FILL = 6'h3F;
	// Control code-groups
	localparam logic [4:0] CODE_IDLE = 5'h1F;
	localparam logic [4:0] CODE_J = 5'h18;
	localparam logic [4:0] CODE_K = 5'h11;
	localparam logic [4:0] CODE_T = 5'h0D;
	localparam logic [4:0] CODE_R = 5'h07;
	// Bit clock cycles per code-group, last bit index
	localparam logic [2:0] BIT_LAST = 3'h4;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	// MLT-3 phases: zero, plus, zero, minus
	localparam logic [1:0] MLT_PLUS = 2'h1;
	localparam logic [1:0] MLT_MINUS = 2'h3;
	localparam logic [1:0] MLT_RESET = 2'h0;
	typedef enum {ENC_IDLE, ENC_SSD_K, ENC_DATA, ENC_ESD_R} enc_state_e;
endpackage

// *** rtl/tx100_scrambler.sv ***
// Closed-loop stream scrambler with bypass, on the bit clock.
// Assumes a synchronous reset already aligned to link_clk.
`timescale 1ns/1ns
module tx100_scrambler (
	// Clock and reset
	input wire logic link_clk,
	input wire logic link_rst,
	// Seed and mode
	input wire logic [tx100_pkg::ADDR_W-1:0] seed_addr_i,
	input wire logic bypass_i,
	// Serial stream
	input wire logic nrz_bit_i,
	output logic scr_bit_o
);
	logic [tx100_pkg::LFSR_W-1:0] lfsr_reg;
	logic [tx100_pkg::LFSR_W-1:0] lfsr_next;
	logic scr_next;

	// Shift and feedback; the LFSR runs every bit so the sequence is free-running
	always_comb begin
		lfsr_next = {lfsr_reg[tx100_pkg::LFSR_W-2:0],
			lfsr_reg[tx100_pkg::LFSR_TAP_HI] ^ lfsr_reg[tx100_pkg::LFSR_TAP_LO]};
		scr_next = bypass_i ? nrz_bit_i : (nrz_bit_i ^ lfsr_reg[tx100_pkg::LFSR_W-1]);
	end

	// Seed taken while reset holds, so each strap address gets its own sequence
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			lfsr_reg <= {tx100_pkg::SEED_FILL, seed_addr_i};
		end else begin
			lfsr_reg <= lfsr_next;
		end
	end

	// Registered scrambled bit
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			scr_bit_o <= 1'b0;
		end else begin
			scr_bit_o <= scr_next;
		end
	end
endmodule // tx100_scrambler

// *** rtl/tx100_mlt3_driver.sv ***
// NRZI encoder and MLT-3 split into two binary drive streams.
// Assumes a synchronous reset already aligned to link_clk.
`timescale 1ns/1ns
module tx100_mlt3_driver (
	// Clock and reset
	input wire logic link_clk,
	input wire logic link_rst,
	// Scrambled NRZ bit
	input wire logic bit_i,
	// Drive streams
	output logic drive_pos_o,
	output logic drive_neg_o
);
	logic nrzi_reg;
	logic nrzi_next;
	logic [1:0] phase_reg;
	logic [1:0] phase_next;

	// A one flips NRZI, and each NRZI flip steps MLT-3 one phase
	always_comb begin
		nrzi_next = nrzi_reg ^ bit_i;
		phase_next = (nrzi_next != nrzi_reg) ? phase_reg + 2'h1 : phase_reg;
	end

	// NRZI level and MLT-3 phase
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			nrzi_reg <= 1'b0;
			phase_reg <= tx100_pkg::MLT_RESET;
		end else begin
			nrzi_reg <= nrzi_next;
			phase_reg <= phase_next;
		end
	end

	// Positive and negative pulses alternate; no binary output path exists
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			drive_pos_o <= 1'b0;
			drive_neg_o <= 1'b0;
		end else begin
			drive_pos_o <= (phase_next == tx100_pkg::MLT_PLUS);
			drive_neg_o <= (phase_next == tx100_pkg::MLT_MINUS);
		end
	end
endmodule // tx100_mlt3_driver

// *** test/tx100_mac_model.sv ***
// Behavioural MAC: sends one frame of random nibbles per start request.
// Assumes start_i changes on the rising edge of clk_i.
`timescale 1ns/1ns
module tx100_mac_model (
	// Clock and request
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic [7:0] len_i,
	// Nibble side
	output logic [3:0] txd_o,
	output logic tx_en_o,
	output logic busy_o
);
	int left = 0;
	initial begin
		txd_o = 4'h0;
		tx_en_o = 1'b0;
	end
	assign busy_o = tx_en_o || left > 0;
	// Falling edge drive keeps nibbles settled at the sampling edge
	always @(negedge clk_i) begin
		if (start_i && left == 0)
			left = len_i;
		tx_en_o <= left > 0;
		txd_o <= left > 0 ? 4'($urandom) : ~txd_o; // Outside frames a stale nibble never lingers
		if (left > 0)
			left--;
	end
endmodule // tx100_mac_model

// *** test/tx100_symbol_encoder_sva.sv ***
// Checker for the transmit coding path, bound to its top module.
// Assumes RST_I stays high long enough for the link side to settle.
`timescale 1ns/1ns
module tx100_symbol_encoder_sva (
	// Clocks and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic LINK_CLK_I,
	// Watched ports
	input wire logic TX_EN_I,
	input wire logic TX_ACTIVE_O,
	input wire logic [tx100_pkg::CODE_W-1:0] CODE_GROUP_O,
	input wire logic MLT3_POS_O,
	input wire logic MLT3_NEG_O
);
	logic last_pos_reg;
	// Sign of the last nonzero level, so two pulses of one sign are caught
	always_ff @(posedge LINK_CLK_I) begin
		if (RST_I)
			last_pos_reg <= 1'b0;
		else if (MLT3_POS_O || MLT3_NEG_O)
			last_pos_reg <= MLT3_POS_O;
	end
	property p_start;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		TX_EN_I && !TX_ACTIVE_O && CODE_GROUP_O == tx100_pkg::CODE_IDLE
		|=> CODE_GROUP_O == tx100_pkg::CODE_J ##1 CODE_GROUP_O == tx100_pkg::CODE_K;
	endproperty
	a_start: assert property (p_start) else $error("start pair wrong");
	property p_end;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		TX_ACTIVE_O && !TX_EN_I && $past(TX_EN_I) && $past(TX_EN_I, 2)
		|=> CODE_GROUP_O == tx100_pkg::CODE_T ##1 CODE_GROUP_O == tx100_pkg::CODE_R;
	endproperty
	a_end: assert property (p_end) else $error("end pair wrong");
	property p_idle;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!TX_EN_I && (CODE_GROUP_O == tx100_pkg::CODE_R || CODE_GROUP_O == tx100_pkg::CODE_IDLE)
		|=> CODE_GROUP_O == tx100_pkg::CODE_IDLE && !TX_ACTIVE_O;
	endproperty
	a_idle: assert property (p_idle) else $error("idle fill broken");
	property p_rise;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		$rose(TX_ACTIVE_O) |-> CODE_GROUP_O == tx100_pkg::CODE_J;
	endproperty
	a_rise: assert property (p_rise) else $error("frame opened without J");
	property p_excl;
		@(posedge LINK_CLK_I) disable iff (RST_I)
		!(MLT3_POS_O && MLT3_NEG_O);
	endproperty
	a_excl: assert property (p_excl) else $error("both streams high");
	property p_plus;
		@(posedge LINK_CLK_I) disable iff (RST_I)
		$rose(MLT3_POS_O) |-> !last_pos_reg && !$past(MLT3_NEG_O);
	endproperty
	a_plus: assert property (p_plus) else $error("plus out of turn");
	property p_minus;
		@(posedge LINK_CLK_I) disable iff (RST_I)
		$rose(MLT3_NEG_O) |-> last_pos_reg && !$past(MLT3_POS_O);
	endproperty
	a_minus: assert property (p_minus) else $error("minus out of turn");
	property p_zero;
		@(posedge LINK_CLK_I) disable iff (RST_I)
		$fell(MLT3_POS_O) |-> !MLT3_NEG_O;
	endproperty
	a_zero: assert property (p_zero) else $error("plus skipped zero");
	c_end: cover property (@(posedge CORE_CLK_I) CODE_GROUP_O == tx100_pkg::CODE_R);
	c_plus: cover property (@(posedge LINK_CLK_I) $rose(MLT3_POS_O));
	c_minus: cover property (@(posedge LINK_CLK_I) $rose(MLT3_NEG_O));
endmodule // tx100_symbol_encoder_sva
bind tx100_symbol_encoder tx100_symbol_encoder_sva sva_u (.CORE_CLK_I(CORE_CLK_I),
	.RST_I(RST_I), .LINK_CLK_I(LINK_CLK_I), .TX_EN_I(TX_EN_I), .TX_ACTIVE_O(TX_ACTIVE_O),
	.CODE_GROUP_O(CODE_GROUP_O), .MLT3_POS_O(MLT3_POS_O), .MLT3_NEG_O(MLT3_NEG_O));

// *** test/tx100_symbol_encoder_tb_top.sv ***
// Self-checking bench: reference encoder, line decoder and descrambler.
// Assumes the bit clock runs five times the nibble clock.
`timescale 1ns/1ns
module tx100_symbol_encoder_tb_top;
	localparam logic [4:0] DATA_CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
		5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic bypass = 1'b1;
	logic start = 1'b0;
	logic [4:0] straps = 5'h00;
	logic [7:0] len = 8'h01;
	logic [3:0] txd;
	logic tx_en, busy, active, pos, neg, b, k;
	logic [4:0] code, e;
	logic [1:0] lvl = 2'h0;
	logic [19:0] win = 20'h0_0000;
	logic [10:0] key = 11'h000;
	logic [10:0] ka = 11'h000;
	int errors = 0;
	int n_compared = 0;
	int jk = 0, lrn = 0, st = 0, cyc = 0;
	// Nibble clock 40 ns, bit clock 8 ns with an unrelated phase
	initial forever #20 core_clk = ~core_clk;
	initial begin
		#3;
		forever #4 link_clk = ~link_clk;
	end
	tx100_symbol_encoder dut_u (.CORE_CLK_I(core_clk), .RST_I(rst), .LINK_CLK_I(link_clk),
		.TXD_I(txd), .TX_EN_I(tx_en), .PHY_ADDRESS_STRAPS_I(straps),
		.SCRAMBLE_BYPASS_I(bypass), .TX_ACTIVE_O(active), .CODE_GROUP_O(code),
		.MLT3_POS_O(pos), .MLT3_NEG_O(neg));
	tx100_mac_model mac_u (.clk_i(core_clk), .start_i(start), .len_i(len), .txd_o(txd),
		.tx_en_o(tx_en), .busy_o(busy));
	task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Reference encoder steps on the sampling edge; a hang ends the run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			summarize();
		end
		if (rst) begin
			st = 0;
			e = tx100_pkg::CODE_IDLE;
		end else case (st)
			0: begin
				e = tx_en ? tx100_pkg::CODE_J : tx100_pkg::CODE_IDLE;
				st = tx_en;
			end
			1: begin
				e = tx100_pkg::CODE_K;
				st = 2;
			end
			2: begin
				e = tx_en ? DATA_CODE[txd] : tx100_pkg::CODE_T;
				st = tx_en ? 2 : 3;
			end
			default: begin
				e = tx100_pkg::CODE_R;
				st = 0;
			end
		endcase
	end
	always @(negedge core_clk) cmp(11'({active, code}), 11'({st != 0, e}));
	// Each level change is a one; the key is learned from scrambled idle, all ones
	always @(posedge link_clk) begin
		b = {pos, neg} != lvl;
		lvl = {pos, neg};
		k = lrn < 11 ? ~b : key[10] ^ key[8];
		key = {key[9:0], k};
		lrn++;
		win = {win[18:0], b ^ (k & !bypass)};
		if (win == 20'hF_FF11)
			jk++;
	end
	// Frames of length one, two and random; each must show idle then J K on the line
	task automatic frames(input int n);
		jk = 0;
		for (int j = 0; j < n; j++) begin
			@(posedge core_clk) start <= 1'b1;
			len <= j < 2 ? 8'(j + 1) : 8'($urandom_range(40, 3));
			@(posedge core_clk) start <= 1'b0;
			while (busy)
				@(posedge core_clk);
			repeat (4) @(posedge core_clk);
		end
		repeat (10) @(posedge core_clk);
		cmp(11'(jk), 11'(n));
	endtask
	initial begin
		void'($urandom(32'h6cf6_01d7));
		straps = 5'($urandom);
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		frames(6);
		@(negedge core_clk) bypass = 1'b0;
		repeat (20) @(negedge core_clk);
		lrn = 0;
		repeat (5) @(negedge core_clk);
		frames(6);
		repeat (2) begin
			@(negedge core_clk) rst = 1'b1;
			straps = straps ^ 5'($urandom_range(31, 1));
			repeat (3) @(negedge core_clk);
			rst = 1'b0;
			repeat (10) @(negedge core_clk);
			lrn = 0;
			repeat (5) @(negedge core_clk);
			cmp(11'(key == ka), 11'h000);
			ka = key;
		end
		summarize();
	end
endmodule // tx100_symbol_encoder_tb_top
